// ==== design/sh_channel.sv ====
// One sample-and-hold channel: sampling window, conversion request and pin discharge
`timescale 1ns/1ps
module sh_channel (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic       trig,
  input  wire logic       ext_tick,
  input  wire logic       clk_sel,
  input  wire logic [3:0] stop_code,
  input  wire logic       discharge_en,
  input  wire logic       conv_done,
  output logic            sampling_q,
  output logic            conv_start_q,
  output logic            discharge_q,
  output logic            busy_q
);

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10
  } ch_state_t;

  ch_state_t  state_q;
  logic       trig_q;
  logic [9:0] count_q;

  // ==========================================================================
  // Edge detection and stop decision
  wire        trig_rise   = trig & ~trig_q;
  wire        trig_fall   = ~trig & trig_q;
  wire        timed_code  = (stop_code >= sh_pkg::FIRST_TIMED_CODE);
  wire [9:0]  per_limit   = sh_pkg::ns_to_cycles(sh_pkg::stop_time_ns(stop_code));
  wire [9:0]  ext_limit   = sh_pkg::EXT_BASE_CYCLES + {6'h00, stop_code};
  wire        ext_stop    = ext_tick && (count_q + 10'h001 >= ext_limit);
  wire        per_stop    = (count_q + 10'h001 >= per_limit);
  // On the peripheral clock, reserved codes 1..3 behave as code 0 so a stray value cannot hang the channel
  wire        stop_now    = clk_sel ? ext_stop :
                            (timed_code ? per_stop : trig_fall);
  wire        count_step  = clk_sel ? ext_tick : 1'b1;

  // Trigger history
  always_ff @(posedge aclk) begin
    if (!aresetn) trig_q <= 1'b0;
    else          trig_q <= trig;
  end

  // Sampling sequence: rise opens the switch, stop point closes it, then convert
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= ST_IDLE;
      count_q      <= 10'h000;
      sampling_q   <= 1'b0;
      conv_start_q <= 1'b0;
      busy_q       <= 1'b0;
    end else begin
      conv_start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          count_q <= 10'h000;
          if (enable && trig_rise) begin
            state_q    <= ST_SAMPLE;
            sampling_q <= 1'b1;
            busy_q     <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          if (count_step) count_q <= count_q + 10'h001;
          if (stop_now) begin
            state_q      <= ST_CONVERT;
            sampling_q   <= 1'b0;
            conv_start_q <= 1'b1;
          end
        end
        ST_CONVERT: begin
          if (conv_done) begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
        end
        default: begin
          state_q    <= ST_IDLE;
          sampling_q <= 1'b0;
          busy_q     <= 1'b0;
        end
      endcase
    end
  end

  // Discharge rises when conversion ends, falls with the next trigger rise
  always_ff @(posedge aclk) begin
    if (!aresetn)                                          discharge_q <= 1'b0;
    else if (trig_rise)                                    discharge_q <= 1'b0;
    else if (state_q == ST_CONVERT && conv_done && discharge_en) discharge_q <= 1'b1;
  end

endmodule : sh_channel

// ==== design/sh_pkg.sv ====
// Shared constants, register map and field layouts for the sample-and-hold trigger control
// Behaviour
// - Two identical channels, each triggered internally or by its own external pin.
// - Sample while pulse high, stop at falling edge, then request conversion.
// - Each channel has its own enable bit in the control register.
// - Single mode: one pulse, internal or channel-0 pin, samples both channels.
// - Single mode: channel-0 flag sets once every enabled channel finished converting.
// - Single mode: channel-0 interrupt enable gates the request for both channels.
// - Single mode: internal trigger enable bits pick the common pulse source.
// - Dual mode bit set: channels run independently from their own pins.
// - Dual mode: each channel has its own internal trigger enable bit.
// - Dual mode: each channel sets its own flag and may request interrupt.
// - Channel 0 results go to buffer location 23, channel 1 to 24.
// - Conversions of both channels use the 1.2V full-scale gain.
// - Fast mode without averaging gives channel 0 conversion priority.
// - With averaging active, slot timing is not guaranteed; priority is dropped.
// - Clock select: 0 peripheral clock, 1 external clock input.
// - Stop codes 4..15, or any code on the external clock, end sampling a set time or cycle count after rise.
// - Peripheral clock: code 0 falling edge, codes 4..15 fixed 300ns..5us delays.
// - External clock: code 0 ends after 21 clocks, each code adds one.
// - Discharge pulse rises after conversion done, falls at next trigger rise.
// - Channel-1 flag only in dual mode with both enabled; never in single.
package sh_pkg;

  // ==========================================================================
  // Register map (byte addresses on the AXI4-Lite bus)
  localparam logic [11:0] ADDR_SH_CONTROL   = 12'h000;
  localparam logic [11:0] ADDR_INT_TRIG_EN  = 12'h004;
  localparam logic [11:0] ADDR_ADC_STATUS   = 12'h008;
  localparam logic [11:0] ADDR_INT_PULSE    = 12'h00C;

  localparam logic [15:0] RST_SH_CONTROL    = 16'h0000;
  localparam logic [1:0]  RST_INT_TRIG_EN   = 2'b00;
  localparam logic [1:0]  RST_INT_PULSE     = 2'b00;

  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS     = 8;
  localparam logic [9:0]  EXT_BASE_CYCLES   = 10'h015;  // 21 external clocks
  localparam logic [3:0]  FIRST_TIMED_CODE  = 4'h4;

  // ==========================================================================
  // Conversion routing
  localparam logic [4:0]  BUF_LOC_CH0       = 5'h17;    // Location 23
  localparam logic [4:0]  BUF_LOC_CH1       = 5'h18;    // Location 24

  // Control register layout, bit 15 first
  typedef struct packed {
    logic [3:0] stop_control_field;
    logic       fast_mode;
    logic       discharge_enable_ch1;
    logic       discharge_enable_ch0;
    logic       dual_mode_bit;
    logic       reserved7;
    logic       align_ch1;
    logic       ch1_interrupt_enable;
    logic       enable_ch1;
    logic       clk_sel;
    logic       align_ch0;
    logic       ch0_interrupt_enable;
    logic       enable_ch0;
  } sh_control_t;

  // Request to the ADC sequencer for one channel
  typedef struct packed {
    logic       start;
    logic [4:0] buf_loc;
    logic       gain_setting_one;
    logic       align;
  } conv_req_t;

  // Delay after the trigger rise for timed stop codes, in ns
  function automatic logic [12:0] stop_time_ns(input logic [3:0] code);
    case (code)
      4'h4:    stop_time_ns = 13'd300;
      4'h5:    stop_time_ns = 13'd350;
      4'h6:    stop_time_ns = 13'd450;
      4'h7:    stop_time_ns = 13'd550;
      4'h8:    stop_time_ns = 13'd750;
      4'h9:    stop_time_ns = 13'd1000;
      4'hA:    stop_time_ns = 13'd1500;
      4'hB:    stop_time_ns = 13'd1750;
      4'hC:    stop_time_ns = 13'd2000;
      4'hD:    stop_time_ns = 13'd2500;
      4'hE:    stop_time_ns = 13'd4000;
      4'hF:    stop_time_ns = 13'd5000;
      default: stop_time_ns = 13'd0;
    endcase
  endfunction : stop_time_ns

  // Least time rounds up to whole clock cycles
  function automatic logic [9:0] ns_to_cycles(input logic [12:0] ns);
    logic [12:0] cyc;
    cyc = (ns + 13'(CLK_PERIOD_NS - 1)) / 13'(CLK_PERIOD_NS);
    ns_to_cycles = cyc[9:0];
  endfunction : ns_to_cycles

endpackage : sh_pkg

// ==== design/sh_trigger_ctrl.sv ====
// Top of the sample-and-hold trigger control with its AXI4-Lite register slave
`timescale 1ns/1ps
module sh_trigger_ctrl (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Pins
  input  wire logic              trigger_in_ch0,
  input  wire logic              trigger_in_ch1,
  input  wire logic              external_clock_input,
  output logic                   sample_ch0,
  output logic                   sample_ch1,
  output logic                   discharge_ch0,
  output logic                   discharge_ch1,
  // ADC sequencer
  output sh_pkg::conv_req_t      conv_req_ch0,
  output sh_pkg::conv_req_t      conv_req_ch1,
  output logic                   fast_priority,
  input  wire logic              adc_avg_active,
  input  wire logic              conv_done_ch0,
  input  wire logic              conv_done_ch1,
  // Interrupt request
  output logic                   irq
);

  // ==========================================================================
  // Registers
  logic [15:0] sh_control_reg_q;
  logic [1:0]  internal_trigger_enable_reg_q;
  logic [1:0]  int_pulse_q;
  logic        ch0_data_avail_flag_q;
  logic        ch1_data_avail_flag_q;
  logic [1:0]  done_seen_q;
  logic [1:0]  pending_q;

  sh_pkg::sh_control_t ctl;
  assign ctl = sh_pkg::sh_control_t'(sh_control_reg_q);

  // ==========================================================================
  // Pin synchronisers: first stage read only by the second
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       ext_clk_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 3'b000;
      sync2_q <= 3'b000;
    end else begin
      sync1_q <= {external_clock_input, trigger_in_ch1, trigger_in_ch0};
      sync2_q <= sync1_q;
    end
  end

  // External clock rising edges become one-cycle enables; it must run well below aclk/2
  always_ff @(posedge aclk) begin
    if (!aresetn) ext_clk_q <= 1'b0;
    else          ext_clk_q <= sync2_q[2];
  end

  wire ext_tick = sync2_q[2] & ~ext_clk_q;
  wire ext_trig0 = sync2_q[0];
  wire ext_trig1 = sync2_q[1];

  // ==========================================================================
  // Trigger routing
  wire dual      = ctl.dual_mode_bit;
  // Single mode: one shared source for both channels, internal when either bit set
  wire single_int = |internal_trigger_enable_reg_q;
  wire single_trig = single_int ? int_pulse_q[0] : ext_trig0;
  // Dual mode: each channel picks its own internal pulse or its own pin
  wire dual_trig0 = internal_trigger_enable_reg_q[0] ? int_pulse_q[0] : ext_trig0;
  wire dual_trig1 = internal_trigger_enable_reg_q[1] ? int_pulse_q[1] : ext_trig1;
  wire trig0     = dual ? dual_trig0 : single_trig;
  wire trig1     = dual ? dual_trig1 : single_trig;

  // ==========================================================================
  // Channels
  logic samp0;
  logic samp1;
  logic start0;
  logic start1;
  logic dis0;
  logic dis1;
  logic busy0;
  logic busy1;

  sh_channel u_ch0 (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .enable       (ctl.enable_ch0),
    .trig         (trig0),
    .ext_tick     (ext_tick),
    .clk_sel      (ctl.clk_sel),
    .stop_code    (ctl.stop_control_field),
    .discharge_en (ctl.discharge_enable_ch0),
    .conv_done    (conv_done_ch0),
    .sampling_q   (samp0),
    .conv_start_q (start0),
    .discharge_q  (dis0),
    .busy_q       (busy0)
  );

  sh_channel u_ch1 (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .enable       (ctl.enable_ch1),
    .trig         (trig1),
    .ext_tick     (ext_tick),
    .clk_sel      (ctl.clk_sel),
    .stop_code    (ctl.stop_control_field),
    .discharge_en (ctl.discharge_enable_ch1),
    .conv_done    (conv_done_ch1),
    .sampling_q   (samp1),
    .conv_start_q (start1),
    .discharge_q  (dis1),
    .busy_q       (busy1)
  );

  // Pin-facing outputs re-registered so every top output is a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_ch0    <= 1'b0;
      sample_ch1    <= 1'b0;
      discharge_ch0 <= 1'b0;
      discharge_ch1 <= 1'b0;
    end else begin
      sample_ch0    <= samp0;
      sample_ch1    <= samp1;
      discharge_ch0 <= dis0;
      discharge_ch1 <= dis1;
    end
  end

  // Conversion requests carry fixed buffer location and gain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_req_ch0  <= '0;
      conv_req_ch1  <= '0;
      fast_priority <= 1'b0;
    end else begin
      conv_req_ch0  <= '{start: start0, buf_loc: sh_pkg::BUF_LOC_CH0,
                         gain_setting_one: 1'b1, align: ctl.align_ch0};
      conv_req_ch1  <= '{start: start1, buf_loc: sh_pkg::BUF_LOC_CH1,
                         gain_setting_one: 1'b1, align: ctl.align_ch1};
      // Averaging breaks the slot guarantee, so priority is withdrawn then
      fast_priority <= ctl.fast_mode & ~adc_avg_active;
    end
  end

  // ==========================================================================
  // Data-available flags
  wire both_en    = ctl.enable_ch0 & ctl.enable_ch1;
  wire [1:0] en_mask = {ctl.enable_ch1, ctl.enable_ch0};
  wire start_any  = start0 | start1;
  wire [1:0] done_now = done_seen_q | {conv_done_ch1 & busy1, conv_done_ch0 & busy0};
  // Single mode: flag 0 once every channel pending in this round has finished
  wire single_set = ~dual && (pending_q != 2'b00) && ((done_now & pending_q) == pending_q);
  wire set0       = dual ? (conv_done_ch0 & busy0) : single_set;
  wire set1       = dual && both_en && conv_done_ch1 && busy1;

  // Round bookkeeping for single mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_q   <= 2'b00;
      done_seen_q <= 2'b00;
    end else if (single_set || dual) begin
      pending_q   <= 2'b00;
      done_seen_q <= 2'b00;
    end else begin
      if (start_any) pending_q <= en_mask;
      done_seen_q <= done_now;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave: one write and one read at a time
  logic       wr_take_q;
  logic       rd_take_q;

  wire        wr_hs     = s_axi_awvalid & s_axi_wvalid & ~wr_take_q & ~s_axi_bvalid;
  wire        rd_hs     = s_axi_arvalid & ~rd_take_q & ~s_axi_rvalid;
  wire        do_write  = wr_take_q;
  wire [11:0] wa        = s_axi_awaddr;
  wire        wa_ctl    = (wa == sh_pkg::ADDR_SH_CONTROL);
  wire        wa_ten    = (wa == sh_pkg::ADDR_INT_TRIG_EN);
  wire        wa_sts    = (wa == sh_pkg::ADDR_ADC_STATUS);
  wire        wa_pls    = (wa == sh_pkg::ADDR_INT_PULSE);
  wire        wa_hit    = wa_ctl | wa_ten | wa_sts | wa_pls;
  wire [15:0] ctl_merge = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : sh_control_reg_q[15:8],
                           s_axi_wstrb[0] ? s_axi_wdata[7:0]  : sh_control_reg_q[7:0]};
  wire        lane0     = do_write & s_axi_wstrb[0];
  // Software clears a flag by writing zero; a same-cycle hardware set wins
  wire        clr0      = lane0 & wa_sts & ~s_axi_wdata[0];
  wire        clr1      = lane0 & wa_sts & ~s_axi_wdata[1];

  // Address and data are taken together, so awready and wready pulse as a pair
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_take_q     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      wr_take_q     <= wr_hs;
      s_axi_awready <= wr_hs;
      s_axi_wready  <= wr_hs;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sh_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wa_hit ? sh_pkg::RESP_OKAY : sh_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control and trigger registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_control_reg_q              <= sh_pkg::RST_SH_CONTROL;
      internal_trigger_enable_reg_q <= sh_pkg::RST_INT_TRIG_EN;
      int_pulse_q                   <= sh_pkg::RST_INT_PULSE;
    end else if (do_write) begin
      if (wa_ctl) sh_control_reg_q <= ctl_merge & 16'hFF7F;
      if (wa_ten && s_axi_wstrb[0]) internal_trigger_enable_reg_q <= s_axi_wdata[1:0];
      if (wa_pls && s_axi_wstrb[0]) int_pulse_q <= s_axi_wdata[1:0];
    end
  end

  // Sticky flags and the interrupt request that follows them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ch0_data_avail_flag_q <= 1'b0;
      ch1_data_avail_flag_q <= 1'b0;
    end else begin
      ch0_data_avail_flag_q <= set0 | (ch0_data_avail_flag_q & ~clr0);
      ch1_data_avail_flag_q <= set1 | (ch1_data_avail_flag_q & ~clr1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else          irq <= (ch0_data_avail_flag_q & ctl.ch0_interrupt_enable) |
                         (dual & ch1_data_avail_flag_q & ctl.ch1_interrupt_enable);
  end

  // Read mux
  wire [11:0] ra       = s_axi_araddr;
  wire        ra_hit   = (ra == sh_pkg::ADDR_SH_CONTROL) | (ra == sh_pkg::ADDR_INT_TRIG_EN) |
                         (ra == sh_pkg::ADDR_ADC_STATUS) | (ra == sh_pkg::ADDR_INT_PULSE);
  wire [31:0] status_w = {26'h000_0000, busy1, busy0, samp1, samp0,
                          ch1_data_avail_flag_q, ch0_data_avail_flag_q};
  wire [31:0] rd_mux   = (ra == sh_pkg::ADDR_SH_CONTROL)  ? {16'h0000, sh_control_reg_q} :
                         (ra == sh_pkg::ADDR_INT_TRIG_EN) ? {30'h0000_0000, internal_trigger_enable_reg_q} :
                         (ra == sh_pkg::ADDR_ADC_STATUS)  ? status_w :
                         (ra == sh_pkg::ADDR_INT_PULSE)   ? {30'h0000_0000, int_pulse_q} :
                                                            32'h0000_0000;

  // Read channel: arready pulses, data one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_take_q     <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      rd_take_q     <= rd_hs;
      s_axi_arready <= rd_hs;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= sh_pkg::RESP_OKAY;
    end else if (rd_take_q) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= ra_hit ? sh_pkg::RESP_OKAY : sh_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : sh_trigger_ctrl

// ==== dv/adc_seq_model.sv ====
// Behavioural ADC sequencer that answers conversion requests
`timescale 1ns/1ps
module adc_seq_model #(
  parameter int LAT0 = 3,
  parameter int LAT1 = 20
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire sh_pkg::conv_req_t conv_req_ch0,
  input  wire sh_pkg::conv_req_t conv_req_ch1,
  output logic                   conv_done_ch0,
  output logic                   conv_done_ch1
);
  logic [7:0] cnt0_q;
  logic [7:0] cnt1_q;
  // Latency counters; channel 1 answers slowly so pairing is exercised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt0_q <= 8'h00;
      cnt1_q <= 8'h00;
    end else begin
      cnt0_q <= conv_req_ch0.start ? 8'(LAT0) : cnt0_q - 8'((cnt0_q != 8'h00));
      cnt1_q <= conv_req_ch1.start ? 8'(LAT1) : cnt1_q - 8'((cnt1_q != 8'h00));
    end
  end
  // One-cycle done pulses, silent in reset
  assign conv_done_ch0 = aresetn && cnt0_q == 8'h01;
  assign conv_done_ch1 = aresetn && cnt1_q == 8'h01;
endmodule : adc_seq_model

// ==== dv/sh_trigger_ctrl_checker.sv ====
// Port assertions for the sample-and-hold trigger control
`timescale 1ns/1ps
module sh_trigger_ctrl_checker (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              sample_ch0,
  input wire logic              sample_ch1,
  input wire logic              discharge_ch0,
  input wire sh_pkg::conv_req_t conv_req_ch0,
  input wire sh_pkg::conv_req_t conv_req_ch1,
  input wire logic              fast_priority,
  input wire logic              adc_avg_active,
  input wire logic              conv_done_ch0,
  input wire logic              conv_done_ch1,
  input wire logic              s_axi_bvalid,
  input wire logic              irq
);
  // ====================================
  // Properties and covers
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Past reset guard keeps a reset-cleared window from looking like a stop
  property p_loc0; conv_req_ch0.start |-> conv_req_ch0.buf_loc == 5'h17 && conv_req_ch0.gain_setting_one; endproperty
  a_loc0: assert property (p_loc0) else $error("ch0 request routing wrong");
  property p_loc1; conv_req_ch1.start |-> conv_req_ch1.buf_loc == 5'h18 && conv_req_ch1.gain_setting_one; endproperty
  a_loc1: assert property (p_loc1) else $error("ch1 request routing wrong");
  property p_fall0; $fell(sample_ch0) && $past(aresetn) |-> conv_req_ch0.start; endproperty
  a_fall0: assert property (p_fall0) else $error("ch0 stop without request");
  property p_fall1; $fell(sample_ch1) && $past(aresetn) |-> conv_req_ch1.start; endproperty
  a_fall1: assert property (p_fall1) else $error("ch1 stop without request");
  property p_start0; conv_req_ch0.start |-> $fell(sample_ch0); endproperty
  a_start0: assert property (p_start0) else $error("ch0 request while sampling");
  property p_dis0; $rose(discharge_ch0) |-> $past(conv_done_ch0, 2); endproperty
  a_dis0: assert property (p_dis0) else $error("discharge not after conversion");
  property p_fast; adc_avg_active |=> !fast_priority; endproperty
  a_fast: assert property (p_fast) else $error("priority kept while averaging");
  property p_irq; $rose(irq) |-> $past(conv_done_ch0, 2) || $past(conv_done_ch1, 2) || $past(s_axi_bvalid); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
  c_pair: cover property (conv_req_ch0.start && conv_req_ch1.start);
  c_dis: cover property ($rose(discharge_ch0));
  c_irq: cover property ($rose(irq));
endmodule : sh_trigger_ctrl_checker

bind sh_trigger_ctrl sh_trigger_ctrl_checker i_sh_trigger_ctrl_checker (.*);

// ==== dv/sh_trigger_ctrl_test.sv ====
// Self-checking bench for the sample-and-hold trigger control
`timescale 1ns/1ps
module sh_trigger_ctrl_test;
  // ====================================
  // Signals and instances
  logic aclk = 1'h0, aresetn = 1'h0, external_clock_input = 1'h0, adc_avg_active = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic trigger_in_ch0 = 1'h0, trigger_in_ch1 = 1'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic sample_ch0, sample_ch1, discharge_ch0, discharge_ch1, fast_priority, irq, conv_done_ch0, conv_done_ch1;
  sh_pkg::conv_req_t conv_req_ch0, conv_req_ch1;
  int num_errors = 0, num_checks = 0;
  localparam int PULSE_GAP = 15625;  // 125us between trigger rises, fast mode on
  sh_trigger_ctrl i_sh_trigger_ctrl (.*);
  adc_seq_model i_adc_seq_model (.*);
  // Free-running clocks; external edges never coincide with aclk rises
  always #4 aclk = ~aclk;
  always #32 external_clock_input = ~external_clock_input;

  // ====================================
  // Helpers
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wait_hi(ref logic s, input int lim);
    int n;
    for (n = 0; n < lim && s !== 1'h1; n++) @(posedge aclk);
    cmp(n < lim, 1'h1);
    if (n == lim) print_verdict();
  endtask : wait_hi
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = sh_pkg::RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    wait_hi(s_axi_wready, 50);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    wait_hi(s_axi_bvalid, 50);
    cmp(s_axi_bresp, er);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er = sh_pkg::RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    wait_hi(s_axi_arready, 50);
    s_axi_arvalid <= 1'h0;
    wait_hi(s_axi_rvalid, 50);
    cmp(s_axi_rdata, exp);
    cmp(s_axi_rresp, er);
  endtask : rd
  // Wait for the flag interrupt, then clear both flags
  task automatic done_clr();
    wait_hi(irq, 100);
    wr(sh_pkg::ADDR_ADC_STATUS, 32'h0000_0000);
  endtask : done_clr
  task automatic stop(input logic [31:0] ctl, input int lo, input int hi);
    int w;
    wr(sh_pkg::ADDR_SH_CONTROL, ctl);
    repeat (PULSE_GAP) @(posedge aclk);
    trigger_in_ch0 <= 1'h1;
    wait_hi(sample_ch0, 20);
    for (w = 0; w < 400 && sample_ch0 === 1'h1; w++) @(posedge aclk);
    cmp(w >= lo && w <= hi, 1'h1);
    trigger_in_ch0 <= 1'h0;
    done_clr();
  endtask : stop

  // ====================================
  // Scenarios
  task automatic t_single();
    rd(sh_pkg::ADDR_SH_CONTROL, 32'h0000_0000);
    wr(sh_pkg::ADDR_SH_CONTROL, 32'h0000_FFFF);
    rd(sh_pkg::ADDR_SH_CONTROL, 32'h0000_FF7F);
    rd(12'h010, 32'h0000_0000, sh_pkg::RESP_SLVERR);
    wr(sh_pkg::ADDR_INT_TRIG_EN, 32'h0000_0001);
    wr(sh_pkg::ADDR_SH_CONTROL, 32'h0000_0813);
    wr(sh_pkg::ADDR_INT_PULSE, 32'h0000_0001);
    wait_hi(sample_ch0, 20);
    cmp(sample_ch1, 1'h1);
    repeat (375) @(posedge aclk);
    wr(sh_pkg::ADDR_INT_PULSE, 32'h0000_0000);
    wait_hi(conv_done_ch0, 100);
    repeat (3) @(posedge aclk);
    cmp(irq, 1'h0);
    wait_hi(irq, 100);
    rd(sh_pkg::ADDR_ADC_STATUS, 32'h0000_0001);
    cmp(irq, 1'h1);
    wr(sh_pkg::ADDR_ADC_STATUS, 32'h0000_0000);
    repeat (2) @(posedge aclk);
    cmp(irq, 1'h0);
  endtask : t_single
  task automatic t_dual();
    wr(sh_pkg::ADDR_INT_TRIG_EN, 32'h0000_0002);
    wr(sh_pkg::ADDR_SH_CONTROL, 32'h0000_0B33);
    repeat (PULSE_GAP) @(posedge aclk);
    wr(sh_pkg::ADDR_INT_PULSE, 32'h0000_0002);
    wait_hi(sample_ch1, 20);
    cmp(sample_ch0, 1'h0);
    repeat (40) @(posedge aclk);
    wr(sh_pkg::ADDR_INT_PULSE, 32'h0000_0000);
    wait_hi(irq, 100);
    rd(sh_pkg::ADDR_ADC_STATUS, 32'h0000_0002);
    wr(sh_pkg::ADDR_ADC_STATUS, 32'h0000_0000);
    for (int i = 0; i < 2; i++) begin
      repeat (PULSE_GAP) @(posedge aclk);
      trigger_in_ch0 <= 1'h1;
      wait_hi(sample_ch0, 20);
      cmp(sample_ch1, 1'h0);
      cmp(discharge_ch0, 1'h0);
      repeat (40) @(posedge aclk);
      trigger_in_ch0 <= 1'h0;
      wait_hi(irq, 100);
      rd(sh_pkg::ADDR_ADC_STATUS, 32'h0000_0001);
      cmp({discharge_ch1, discharge_ch0}, 2'h1);
      wr(sh_pkg::ADDR_ADC_STATUS, 32'h0000_0000);
    end
  endtask : t_dual
  task automatic t_timing();
    wr(sh_pkg::ADDR_INT_TRIG_EN, 32'h0000_0000);
    stop(32'h0000_4803, 37, 39);
    stop(32'h0000_080B, 158, 178);
    wr(sh_pkg::ADDR_SH_CONTROL, 32'h0000_0800);
    repeat (3) @(posedge aclk);
    cmp(fast_priority, 1'h1);
    adc_avg_active <= 1'h1;
    repeat (3) @(posedge aclk);
    cmp(fast_priority, 1'h0);
    adc_avg_active <= 1'h0;
  endtask : t_timing

  // Reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_single();
    t_dual();
    t_timing();
    print_verdict();
  end
endmodule : sh_trigger_ctrl_test
